// file: hdl/sdc_pkg.sv
// Shared constants, command codes and carrier types for the command decoder
package sdc_pkg;
  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int BANKS = 8;
  localparam int BA_W = 3;
  localparam int ADDR_W = 14;
  localparam int DQ_W = 8;
  localparam int IMP_W = 6;
  localparam int AP_BIT = 10;
  localparam int CHOP_BIT = 12;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 50;
  localparam int SHORT_CAL_WINDOW_CK = 64;
  localparam int ROW_PRECHARGE_NS = 15;
  localparam int ROW_PRECHARGE_CYC = (ROW_PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int REFRESH_CYCLE_NS = 110;
  localparam int REFRESH_CYCLE_CYC = (REFRESH_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int FULL_BURST_EIGHT = 8;
  localparam int CHOPPED_BURST_FOUR = 4;
  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [IMP_W-1:0] IMP_RESET = 6'h20;
  localparam logic [IMP_W-1:0] IMP_MAX = 6'h3F;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_ZQ = 3'h6;
  typedef enum logic [2:0] {BK_IDLE = 3'h1, BK_ACTIVE = 3'h2, BK_PRECH = 3'h4} sdc_bank_st_t;
  typedef enum logic [2:0] {BR_IDLE = 3'h1, BR_READ = 3'h2, BR_WRITE = 3'h4} sdc_burst_st_t;
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } sdc_pins_t;
  typedef struct packed {
    logic write_byte_mask;
    logic [DQ_W-1:0] dq;
  } sdc_wbeat_t;
endpackage

// file: hdl/sdc_bank.sv
// One bank: idle, active with an open row, or precharging
`timescale 1ns/100ps
module sdc_bank #(
  parameter int ROW_W = 14
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Commands
  input wire logic act_i,
  input wire logic pre_i,
  input wire logic [ROW_W-1:0] row_i,
  // State
  output sdc_pkg::sdc_bank_st_t state_q,
  output logic [ROW_W-1:0] row_q
);
  logic [3:0] timer_q;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_q <= sdc_pkg::BK_IDLE;
      timer_q <= 4'h0;
      row_q <= '0;
    end
    else
    begin
      case (state_q)
        sdc_pkg::BK_IDLE:
        begin
          if (act_i)
          begin
            state_q <= sdc_pkg::BK_ACTIVE; // see R2
            row_q <= row_i;
          end
        end
        sdc_pkg::BK_ACTIVE:
        begin
          if (pre_i)
          begin
            state_q <= sdc_pkg::BK_PRECH; // see R2
            timer_q <= 4'(sdc_pkg::ROW_PRECHARGE_CYC);
          end
        end
        sdc_pkg::BK_PRECH:
        begin
          if (pre_i)
            timer_q <= 4'(sdc_pkg::ROW_PRECHARGE_CYC); // see R15
          else if (timer_q <= 4'h1)
            state_q <= sdc_pkg::BK_IDLE;
          else
            timer_q <= timer_q - 4'h1;
        end
        default:
          state_q <= sdc_pkg::BK_IDLE;
      endcase
    end
  end
endmodule

// file: hdl/sdc_core.sv
// Command decoder, bank tracking, burst engine, refresh and short calibration
`timescale 1ns/100ps
// Summary of operation
// R1 - Short calibration nudges impedance within 64 clocks
// R2 - Activate opens row until bank precharge
// R3 - Controller precharges before another row opens
// R4 - Low column bits set burst start order
// R5 - Auto-precharge bit closes row after read or write burst
// R6 - Chop bit picks four or eight beats
// R7 - Started bursts always run to completion
// R8 - Read and write decoded from pin pattern
// R9 - Write bursts into open row of bank
// R10 - Masked write bytes are left unchanged
// R11 - Controller waits precharge time before activate
// R12 - Other-bank access allowed during auto-precharge
// R13 - Auto-precharge bit high on precharge closes every bank
// R14 - Controller activates before reading or writing
// R15 - Precharge to idle bank is no-op
// R16 - Refresh uses internal row counter
// R17 - Controller refreshes every 7.8 or 3.9 us
// R18 - Only no-ops until refresh cycle ends
// R19 - At most eight refreshes postponed
// R20 - Beyond eight allowed within 64 ms
// R21 - Clock gate high for precharge, activate, refresh
// R22 - First write 512 clocks after reference valid
// R23 - Commands sampled at input clock rising edge
// R24 - Refresh with clock gate falling enters self refresh
// R25 - Commands checked against per-bank state
module sdc_core #(
  parameter int ROW_W = 14
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Device pins
  input wire logic ck,
  input sdc_pkg::sdc_pins_t pins,
  input sdc_pkg::sdc_wbeat_t wbeat,
  input wire logic imp_cmp,
  // Configuration
  input wire logic otf_enable,
  input wire logic fixed_chop,
  input wire logic interleave,
  // Read data
  output logic [sdc_pkg::DQ_W-1:0] rd_data_q,
  output logic rd_valid_q,
  // Status
  output logic store_en_q,
  output logic [2:0] beat_col_q,
  output logic [3:0] burst_len_q,
  output logic [sdc_pkg::BANKS-1:0] bank_open_q,
  output logic [15:0] refresh_row_q,
  output logic refresh_busy_q,
  output logic self_ref_q,
  output logic cal_busy_q,
  output logic [sdc_pkg::IMP_W-1:0] imp_code_q,
  output logic cmd_error_q
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic ck_s1_q, ck_s2_q, ck_s3_q;
  sdc_pkg::sdc_pins_t pins_s1_q, pins_s2_q;
  sdc_pkg::sdc_wbeat_t wb_s1_q, wb_s2_q;
  logic cmp_s1_q, cmp_s2_q;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ck_s1_q <= 1'b0;
      ck_s2_q <= 1'b0;
      ck_s3_q <= 1'b0;
      pins_s1_q <= '1;
      pins_s2_q <= '1;
      wb_s1_q <= '1;
      wb_s2_q <= '1;
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
    end
    else
    begin
      ck_s1_q <= ck;
      ck_s2_q <= ck_s1_q;
      ck_s3_q <= ck_s2_q;
      pins_s1_q <= pins;
      pins_s2_q <= pins_s1_q;
      wb_s1_q <= wbeat;
      wb_s2_q <= wb_s1_q;
      cmp_s1_q <= imp_cmp;
      cmp_s2_q <= cmp_s1_q;
    end
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  logic ck_rise, ck_edge, cke_prev_q, cmd_ok, ap_bit, chop_select_bit;
  logic [2:0] cmd;
  logic [sdc_pkg::BA_W-1:0] cmd_ba;
  logic [sdc_pkg::BANKS-1:0] act_vec, pre_vec, bank_act_w, bank_idle_w;
  sdc_pkg::sdc_bank_st_t bank_st [sdc_pkg::BANKS];
  logic all_idle, act_go, pre_all, ref_ok, sr_entry, zq_go, rw_req, rw_go;
  logic beat_go, beat_last, ap_done;
  sdc_pkg::sdc_burst_st_t burst_q;
  logic [sdc_pkg::BA_W-1:0] burst_bank_q;

  assign ck_rise = ck_s2_q & ~ck_s3_q; // see R23
  assign ck_edge = ck_s2_q ^ ck_s3_q;
  assign cmd = {pins_s2_q.ras_n, pins_s2_q.cas_n, pins_s2_q.we_n};
  assign cmd_ba = pins_s2_q.ba;
  assign ap_bit = pins_s2_q.addr[sdc_pkg::AP_BIT];
  assign chop_select_bit = pins_s2_q.addr[sdc_pkg::CHOP_BIT];
  assign cmd_ok = ck_rise & ~pins_s2_q.cs_n & cke_prev_q & pins_s2_q.cke & ~self_ref_q; // see R8
  assign all_idle = &bank_idle_w;
  assign act_go = cmd_ok & (cmd == sdc_pkg::CMD_ACT) & bank_idle_w[cmd_ba]; // see R25
  assign pre_all = cmd_ok & (cmd == sdc_pkg::CMD_PRE) & ap_bit; // see R13
  assign ref_ok = cmd_ok & (cmd == sdc_pkg::CMD_REF) & all_idle;
  assign sr_entry = ck_rise & ~pins_s2_q.cs_n & cke_prev_q & ~pins_s2_q.cke & ~self_ref_q
                    & (cmd == sdc_pkg::CMD_REF) & all_idle; // see R24
  assign zq_go = cmd_ok & (cmd == sdc_pkg::CMD_ZQ) & ~ap_bit & ~cal_busy_q;
  assign rw_req = cmd_ok & ((cmd == sdc_pkg::CMD_RD) | (cmd == sdc_pkg::CMD_WR)); // see R8
  assign rw_go = rw_req & (burst_q == sdc_pkg::BR_IDLE) & bank_act_w[cmd_ba]; // see R7

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      cke_prev_q <= 1'b0;
    else if (ck_rise)
      cke_prev_q <= pins_s2_q.cke;
  end

  // ----------------------------------------
  // Banks
  // ----------------------------------------
  genvar gb;
  generate
    for (gb = 0; gb < sdc_pkg::BANKS; gb++)
    begin : g_bank
      assign act_vec[gb] = act_go & (cmd_ba == sdc_pkg::BA_W'(gb));
      assign pre_vec[gb] = (cmd_ok & (cmd == sdc_pkg::CMD_PRE)
                            & (ap_bit | (cmd_ba == sdc_pkg::BA_W'(gb)))) // see R13
                           | (ap_done & (burst_bank_q == sdc_pkg::BA_W'(gb))); // see R5
      assign bank_act_w[gb] = bank_st[gb] == sdc_pkg::BK_ACTIVE;
      assign bank_idle_w[gb] = bank_st[gb] == sdc_pkg::BK_IDLE;
      sdc_bank #(.ROW_W(ROW_W)) u_bank (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .act_i(act_vec[gb]),
        .pre_i(pre_vec[gb]),
        .row_i(pins_s2_q.addr[ROW_W-1:0]),
        .state_q(bank_st[gb]),
        .row_q()
      );
    end
  endgenerate

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      bank_open_q <= '0;
    else
      bank_open_q <= bank_act_w;
  end

  // ----------------------------------------
  // Burst engine
  // ----------------------------------------
  logic burst_ap_q, burst_chop_q, burst_il_q;
  logic [2:0] start_q, beat_q, col_w;
  logic [sdc_pkg::DQ_W-1:0] buf_q [8];
  logic chop_pick;

  assign chop_pick = otf_enable ? ~chop_select_bit : fixed_chop; // see R6
  assign beat_go = (burst_q != sdc_pkg::BR_IDLE) & ck_edge;
  assign beat_last = beat_go & (beat_q == (burst_chop_q ? 3'h3 : 3'h7)); // see R7
  assign ap_done = beat_last & burst_ap_q; // see R5
  assign col_w = burst_il_q ? (start_q ^ beat_q)
                 : {start_q[2] ^ beat_q[2], start_q[1:0] + beat_q[1:0]}; // see R4

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      burst_q <= sdc_pkg::BR_IDLE;
      burst_bank_q <= '0;
      burst_ap_q <= 1'b0;
      burst_chop_q <= 1'b0;
      burst_il_q <= 1'b0;
      start_q <= 3'h0;
      beat_q <= 3'h0;
      burst_len_q <= 4'h0;
    end
    else
    begin
      case (burst_q)
        sdc_pkg::BR_IDLE:
        begin
          if (rw_go)
          begin
            burst_q <= (cmd == sdc_pkg::CMD_WR) ? sdc_pkg::BR_WRITE : sdc_pkg::BR_READ; // see R9
            burst_bank_q <= cmd_ba;
            burst_ap_q <= ap_bit; // see R5
            burst_chop_q <= chop_pick;
            burst_len_q <= chop_pick ? 4'(sdc_pkg::CHOPPED_BURST_FOUR)
                           : 4'(sdc_pkg::FULL_BURST_EIGHT); // see R6
            burst_il_q <= interleave;
            start_q <= pins_s2_q.addr[2:0]; // see R4
            beat_q <= 3'h0;
          end
        end
        sdc_pkg::BR_READ, sdc_pkg::BR_WRITE:
        begin
          if (beat_last)
            burst_q <= sdc_pkg::BR_IDLE;
          if (beat_go)
            beat_q <= beat_q + 3'h1;
        end
        default:
          burst_q <= sdc_pkg::BR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rd_data_q <= '0;
      rd_valid_q <= 1'b0;
      store_en_q <= 1'b0;
      beat_col_q <= 3'h0;
      for (int i = 0; i < 8; i++)
        buf_q[i] <= '0;
    end
    else
    begin
      rd_valid_q <= beat_go & (burst_q == sdc_pkg::BR_READ);
      store_en_q <= beat_go & (burst_q == sdc_pkg::BR_WRITE) & ~wb_s2_q.write_byte_mask;
      if (beat_go)
      begin
        beat_col_q <= col_w;
        if (burst_q == sdc_pkg::BR_READ)
          rd_data_q <= buf_q[col_w];
        else if (!wb_s2_q.write_byte_mask)
          buf_q[col_w] <= wb_s2_q.dq; // see R10
      end
    end
  end

  // ----------------------------------------
  // Refresh, self refresh and errors
  // ----------------------------------------
  logic [3:0] ref_cnt_q;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      refresh_row_q <= 16'h0000;
      ref_cnt_q <= 4'h0;
      refresh_busy_q <= 1'b0;
      self_ref_q <= 1'b0;
    end
    else
    begin
      if (ref_ok | sr_entry)
        refresh_row_q <= refresh_row_q + 16'h0001; // see R16
      if (ref_ok)
      begin
        ref_cnt_q <= 4'(sdc_pkg::REFRESH_CYCLE_CYC);
        refresh_busy_q <= 1'b1;
      end
      else if (ref_cnt_q > 4'h1)
        ref_cnt_q <= ref_cnt_q - 4'h1;
      else
      begin
        ref_cnt_q <= 4'h0;
        refresh_busy_q <= 1'b0;
      end
      if (sr_entry)
        self_ref_q <= 1'b1; // see R24
      else if (self_ref_q & pins_s2_q.cke)
        self_ref_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      cmd_error_q <= 1'b0;
    else
      cmd_error_q <= (cmd_ok & (cmd == sdc_pkg::CMD_ACT) & ~bank_idle_w[cmd_ba])
                     | (rw_req & ~rw_go)
                     | (cmd_ok & (cmd == sdc_pkg::CMD_REF) & ~all_idle); // see R25
  end

  // ----------------------------------------
  // Short impedance calibration
  // ----------------------------------------
  logic [6:0] cal_cnt_q;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cal_cnt_q <= 7'h00;
      cal_busy_q <= 1'b0;
      imp_code_q <= sdc_pkg::IMP_RESET;
    end
    else if (zq_go)
    begin
      cal_cnt_q <= 7'(sdc_pkg::SHORT_CAL_WINDOW_CK); // see R1
      cal_busy_q <= 1'b1;
    end
    else if (cal_busy_q & ck_rise)
    begin
      cal_cnt_q <= cal_cnt_q - 7'h01;
      if (cal_cnt_q == 7'h01)
      begin
        cal_busy_q <= 1'b0;
        if (cmp_s2_q && imp_code_q != sdc_pkg::IMP_MAX)
          imp_code_q <= imp_code_q + 6'h01; // see R1
        else if (!cmp_s2_q && imp_code_q != 6'h00)
          imp_code_q <= imp_code_q - 6'h01;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_cal_step;
    $fell(cal_busy_q) |-> $changed(imp_code_q) || imp_code_q == 6'h00 || imp_code_q == 6'h3F;
  endproperty
  a_cal_step: assert property (p_cal_step) else $error("calibration ended without a step"); // see R1

  property p_act_opens;
    act_go |=> ##1 bank_open_q[$past(cmd_ba, 2)];
  endproperty
  a_act_opens: assert property (p_act_opens) else $error("activate did not open bank"); // see R2

  property p_first_col;
    beat_go && beat_q == 3'h0 |=> beat_col_q == $past(start_q);
  endproperty
  a_first_col: assert property (p_first_col) else $error("burst did not start at column"); // see R4

  property p_autoclose;
    ap_done |=> ##1 !bank_open_q[$past(burst_bank_q, 2)];
  endproperty
  a_autoclose: assert property (p_autoclose) else $error("auto-precharge left row open"); // see R5

  property p_len;
    rw_go |=> burst_len_q == (otf_enable ? ($past(chop_select_bit) ? 4'h8 : 4'h4)
                              : (fixed_chop ? 4'h4 : 4'h8));
  endproperty
  a_len: assert property (p_len) else $error("wrong burst length"); // see R6

  property p_no_interrupt;
    rw_req && burst_q != sdc_pkg::BR_IDLE |=> cmd_error_q && $stable(burst_bank_q);
  endproperty
  a_no_interrupt: assert property (p_no_interrupt) else $error("burst was interrupted"); // see R7

  property p_mask;
    beat_go && burst_q == sdc_pkg::BR_WRITE |=> store_en_q == !$past(wb_s2_q.write_byte_mask);
  endproperty
  a_mask: assert property (p_mask) else $error("write mask not honoured"); // see R10

  property p_pre_all;
    pre_all |=> ##1 bank_open_q == '0;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open"); // see R13

  property p_refresh_row;
    ref_ok |=> refresh_row_q == $past(refresh_row_q) + 16'h0001 && refresh_busy_q;
  endproperty
  a_refresh_row: assert property (p_refresh_row) else $error("refresh row not advanced"); // see R16

  property p_self_ref;
    sr_entry |=> self_ref_q;
  endproperty
  a_self_ref: assert property (p_self_ref) else $error("self refresh not entered"); // see R24
endmodule

// file: verif/sdc_ctrl_model.sv
// Controller-side model driving the command clock, command pins and write beats
`timescale 1ns/100ps
module sdc_ctrl_model (
  // Clock
  input wire logic clk_sys,
  // Device pins
  output logic ck,
  output sdc_pkg::sdc_pins_t pins,
  output sdc_pkg::sdc_wbeat_t wbeat
);
  // ----------------------------------------
  // Idle levels: deselected, clock gate high
  // ----------------------------------------
  initial
  begin
    ck = 1'b0;
    pins = '1;
    wbeat = '1;
  end

  // ----------------------------------------
  // One half period: pins set two cycles before the clock moves and held two after
  // ----------------------------------------
  task automatic half(input sdc_pkg::sdc_pins_t p, input sdc_pkg::sdc_wbeat_t w);
    @(posedge clk_sys);
    pins <= p;
    wbeat <= w;
    repeat (2) @(posedge clk_sys);
    ck <= ~ck;
    @(posedge clk_sys);
  endtask
endmodule

// file: verif/testbench.sv
// Self-checking testbench for the command decoder
`timescale 1ns/100ps
`define CHK(a, e) \
  begin \
    compares++; \
    if ((a) !== (e)) \
    begin \
      errors++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); \
    end \
  end
module testbench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic imp_cmp = 1'b1;
  logic otf_enable = 1'b1;
  logic fixed_chop = 1'b0;
  logic interleave = 1'b0;
  logic ck;
  sdc_pkg::sdc_pins_t pins;
  sdc_pkg::sdc_wbeat_t wbeat;
  logic [7:0] rd_data_q;
  logic rd_valid_q;
  logic store_en_q;
  logic [2:0] beat_col_q;
  logic [3:0] burst_len_q;
  logic [7:0] bank_open_q;
  logic [15:0] refresh_row_q;
  logic refresh_busy_q;
  logic self_ref_q;
  logic cal_busy_q;
  logic [5:0] imp_code_q;
  logic cmd_error_q;
  int errors = 0;
  int compares = 0;
  int err_seen = 0;
  int exp_err = 0;
  int busy_cyc = 0;
  logic [31:0] seed = 32'h000124FC;
  logic [7:0] mem [8];
  logic [11:0] expq [$];

  always #25 clk_sys = ~clk_sys;

  sdc_ctrl_model sdc_ctrl_model_i (.clk_sys(clk_sys), .ck(ck), .pins(pins), .wbeat(wbeat));

  sdc_core sdc_core_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .ck(ck), .pins(pins), .wbeat(wbeat),
    .imp_cmp(imp_cmp), .otf_enable(otf_enable), .fixed_chop(fixed_chop),
    .interleave(interleave), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
    .store_en_q(store_en_q), .beat_col_q(beat_col_q), .burst_len_q(burst_len_q),
    .bank_open_q(bank_open_q), .refresh_row_q(refresh_row_q),
    .refresh_busy_q(refresh_busy_q), .self_ref_q(self_ref_q), .cal_busy_q(cal_busy_q),
    .imp_code_q(imp_code_q), .cmd_error_q(cmd_error_q)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic sdc_pkg::sdc_wbeat_t idle();
    logic [31:0] r;
    r = rnd();
    return {1'b1, r[7:0]};
  endfunction

  function automatic sdc_pkg::sdc_pins_t pk(input logic [2:0] c, input logic k,
    input logic [2:0] b, input logic [13:0] a);
    return {1'b0, c, k, b, a};
  endfunction

  task automatic cmd(input logic [2:0] c, input logic [2:0] b, input logic [13:0] a);
    sdc_ctrl_model_i.half(pk(c, 1'b1, b, a), idle());
    sdc_ctrl_model_i.half(pk(3'h7, 1'b1, 3'h0, 14'h0000), idle());
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic burst(input logic w, input logic [2:0] s, input logic ap, input logic ch,
    input logic mk, input logic br);
    int n;
    logic [2:0] c;
    logic [2:0] ib;
    logic [31:0] r;
    sdc_pkg::sdc_wbeat_t bt;
    sdc_ctrl_model_i.half(pk(w ? sdc_pkg::CMD_WR : sdc_pkg::CMD_RD, 1'b1, 3'h2,
      {1'b0, ch, 1'b0, ap, 7'h00, s}), idle());
    n = otf_enable ? (ch ? 8 : 4) : (fixed_chop ? 4 : 8);
    for (int i = 0; i < n; i++)
    begin
      ib = 3'(i);
      c = interleave ? s ^ ib : {s[2] ^ ib[2], s[1:0] + ib[1:0]};
      r = rnd();
      bt = {mk & r[8], r[7:0]};
      if (w && !bt.write_byte_mask)
      begin
        mem[c] = bt.dq;
        expq.push_back({1'b0, c, 8'h00});
      end
      if (!w)
        expq.push_back({1'b1, c, mem[c]});
      sdc_ctrl_model_i.half(pk((br && i == 1) ? sdc_pkg::CMD_RD : 3'h7, 1'b1, 3'h2,
        14'h0000), w ? bt : idle());
    end
    sdc_ctrl_model_i.half(pk(3'h7, 1'b1, 3'h0, 14'h0000), idle());
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic print_verdict();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------
  // Output watcher
  // ----------------------------------------
  always @(posedge clk_sys)
  begin
    if (cmd_error_q === 1'b1)
      err_seen++;
    if (refresh_busy_q === 1'b1)
      busy_cyc++;
    if (store_en_q === 1'b1 || rd_valid_q === 1'b1)
    begin
      if (expq.size() == 0)
        `CHK(1'b1, 1'b0)
      else
        `CHK({rd_valid_q, beat_col_q, rd_valid_q ? rd_data_q : 8'h00}, expq.pop_front())
    end
  end

  initial
  begin
    repeat (40000) @(posedge clk_sys);
    errors++;
    print_verdict();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    cmd(3'h7, 3'h0, 14'h0000);
    cmd(sdc_pkg::CMD_ACT, 3'h2, 14'h0123);
    `CHK(bank_open_q, 8'h04)
    cmd(sdc_pkg::CMD_ACT, 3'h2, 14'h0456);
    exp_err++;
    `CHK(err_seen, exp_err)
    burst(1'b1, 3'h5, 1'b0, 1'b1, 1'b0, 1'b0);
    burst(1'b1, 3'h3, 1'b0, 1'b1, 1'b1, 1'b1);
    exp_err++;
    `CHK(err_seen, exp_err)
    `CHK(burst_len_q, 4'h8)
    interleave <= 1'b1;
    burst(1'b0, 3'h6, 1'b0, 1'b0, 1'b0, 1'b0);
    interleave <= 1'b0;
    otf_enable <= 1'b0;
    fixed_chop <= 1'b1;
    burst(1'b0, 3'h1, 1'b1, 1'b1, 1'b0, 1'b0);
    `CHK(burst_len_q, 4'h4)
    `CHK(bank_open_q, 8'h00)
    cmd(sdc_pkg::CMD_RD, 3'h2, 14'h0000);
    exp_err++;
    cmd(sdc_pkg::CMD_PRE, 3'h2, 14'h0000);
    `CHK(err_seen, exp_err)
    cmd(sdc_pkg::CMD_ACT, 3'h1, 14'h0011);
    cmd(sdc_pkg::CMD_ACT, 3'h3, 14'h0022);
    `CHK(bank_open_q, 8'h0A)
    cmd(sdc_pkg::CMD_REF, 3'h0, 14'h0000);
    exp_err++;
    cmd(sdc_pkg::CMD_PRE, 3'h0, 14'h0400);
    `CHK(bank_open_q, 8'h00)
    `CHK(err_seen, exp_err)
    cmd(sdc_pkg::CMD_ACT, 3'h4, 14'h0033);
    cmd(sdc_pkg::CMD_PRE, 3'h5, 14'h0000);
    `CHK(bank_open_q, 8'h10)
    cmd(sdc_pkg::CMD_PRE, 3'h4, 14'h0000);
    `CHK(bank_open_q, 8'h00)
    cmd(sdc_pkg::CMD_REF, 3'h7, 14'h3FFF);
    cmd(sdc_pkg::CMD_REF, 3'h0, 14'h0000);
    `CHK(refresh_row_q, 16'h0002)
    `CHK(busy_cyc, 2 * sdc_pkg::REFRESH_CYCLE_CYC)
    cmd(sdc_pkg::CMD_ZQ, 3'h0, 14'h0000);
    `CHK(cal_busy_q, 1'b1)
    repeat (62) cmd(3'h7, 3'h0, 14'h0000);
    `CHK(cal_busy_q, 1'b1)
    repeat (4) cmd(3'h7, 3'h0, 14'h0000);
    `CHK(cal_busy_q, 1'b0)
    `CHK(imp_code_q, sdc_pkg::IMP_RESET + 6'h01)
    imp_cmp <= 1'b0;
    cmd(sdc_pkg::CMD_ZQ, 3'h0, 14'h0000);
    repeat (66) cmd(3'h7, 3'h0, 14'h0000);
    `CHK(imp_code_q, sdc_pkg::IMP_RESET)
    sdc_ctrl_model_i.half(pk(sdc_pkg::CMD_REF, 1'b0, 3'h0, 14'h0000), idle());
    sdc_ctrl_model_i.half(pk(3'h7, 1'b0, 3'h0, 14'h0000), idle());
    repeat (3) @(posedge clk_sys);
    `CHK(self_ref_q, 1'b1)
    `CHK(refresh_row_q, 16'h0003)
    repeat (2) cmd(3'h7, 3'h0, 14'h0000);
    `CHK(self_ref_q, 1'b0)
    `CHK(expq.size(), 0)
    `CHK(err_seen, exp_err)
    print_verdict();
  end
endmodule
